// ### rtl/bms_top.sv
`timescale 1ns/10ps
module bms_top
    import bms_pkg::*;
#(
    parameter logic [7:0] LOADER_VER = VER_7_4,
    parameter logic [31:0] DIS_CODE = 32'h5a5a_a5a5,  // Arbitrary value
    parameter int FLASH_AW = 16,
    parameter int DEADLINE_CYC = BOOT_DEADLINE_CYC,
    parameter int ERASE_TIME_CYC = ERASE_CYC,
    parameter int PROG_TIME_CYC = PROG_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Board straps and reset cause
    input wire logic prog_request_strap_i,
    input wire logic iface_select_strap_i,
    input wire logic wdt_overflow_i,
    // Flash read and timing port
    output logic flash_rd_o,
    output logic [FLASH_AW-1:0] flash_addr_o,
    input wire logic [31:0] flash_rdata_i,
    input wire logic flash_ack_i,
    output logic flash_erase_o,
    output logic flash_prog_o,
    // Boot outcome
    output logic boot_done_o,
    output logic [1:0] boot_mode_o,
    output logic run_user_o,
    output logic usb_msc_en_o,
    output logic serial_pins_en_o
);
    localparam int DLW = $clog2(DEADLINE_CYC + 1);
    localparam int TW = $clog2(ERASE_TIME_CYC + PROG_TIME_CYC + 1);
    localparam int SW = $clog2(STRAP_SETTLE_CYC + 1);
    //--------------------------------------------------------------------
    // Strap synchronisers
    //--------------------------------------------------------------------
    logic [1:0] prog_meta_q, prog_meta_d;  // Request strap sync chain
    logic [1:0] iface_meta_q, iface_meta_d;  // Interface strap sync chain
    wire logic prog_s = prog_meta_q[1];  // Synchronised request strap
    wire logic iface_s = iface_meta_q[1];  // Synchronised interface strap
    // Two stages; only the second stage is read
    always_comb begin
        prog_meta_d = {prog_meta_q[0], prog_request_strap_i};
        iface_meta_d = {iface_meta_q[0], iface_select_strap_i};
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prog_meta_q <= 2'h3;  // Idle high: no request
            iface_meta_q <= 2'h0;
        end else begin
            prog_meta_q <= prog_meta_d;
            iface_meta_q <= iface_meta_d;
        end
    end
    //--------------------------------------------------------------------
    // Version dependent strap decode
    //--------------------------------------------------------------------
    // Mode requested by straps, or none
    function automatic bms_mode_type req_mode(input logic prog,
                                              input logic iface);
        if (prog) return BM_NONE;  // High strap: no request
        if (LOADER_VER == VER_7_1) return BM_UART;  // Iface ignored
        if (LOADER_VER >= VER_7_4) return iface ? BM_USB : BM_UART;
        return iface ? BM_NONE : BM_UART;  // 7.0 needs both low
    endfunction
    // Programming path when no valid code exists
    function automatic bms_mode_type fall_mode(input logic iface);
        return (LOADER_VER >= VER_7_4 && iface) ? BM_USB : BM_UART;
    endfunction
    //--------------------------------------------------------------------
    // Boot sequencer
    //--------------------------------------------------------------------
    bms_state_type st_q, st_d;  // Sequencer state
    logic [SW-1:0] settle_q, settle_d;  // Strap settle counter
    logic [DLW-1:0] dl_q, dl_d;  // Decision deadline counter
    logic [2:0] idx_q, idx_d;  // Vector word index
    logic [31:0] sum_q, sum_d;  // Vector checksum
    logic rd_q, rd_d;  // Flash read request
    logic [FLASH_AW-1:0] addr_q, addr_d;  // Flash read address
    bms_mode_type mode_q, mode_d;  // Chosen boot path
    logic dis_q, dis_d;  // Strap sampling disabled
    logic wdt_q, wdt_d;  // Watchdog flag seen
    logic pstrap_q, pstrap_d;  // Sampled request strap
    logic istrap_q, istrap_d;  // Sampled interface strap
    logic sum_ok_q, sum_ok_d;  // Valid code found
    logic dl_hit_q, dl_hit_d;  // Deadline forced the choice
    logic reboot;  // Software restart pulse
    logic vec_we;  // Store one vector word
    // Next state of the sequencer
    always_comb begin
        st_d = st_q;
        settle_d = settle_q;
        dl_d = dl_q;
        idx_d = idx_q;
        sum_d = sum_q;
        rd_d = rd_q;
        addr_d = addr_q;
        mode_d = mode_q;
        dis_d = dis_q;
        wdt_d = wdt_q;
        pstrap_d = pstrap_q;
        istrap_d = istrap_q;
        sum_ok_d = sum_ok_q;
        dl_hit_d = dl_hit_q;
        vec_we = 1'b0;
        if (st_q != ST_DONE) dl_d = dl_q + DLW'(1);  // Deadline clock
        case (st_q)
            ST_SETTLE: begin
                settle_d = settle_q + SW'(1);  // Straps settle first
                if (settle_q == SW'(STRAP_SETTLE_CYC - 1)) begin
                    rd_d = 1'b1;
                    addr_d = FLASH_AW'(DIS_WORD_ADDR);
                    wdt_d = wdt_overflow_i;
                    st_d = ST_DISRD;
                end
            end
            ST_DISRD: begin
                if (flash_ack_i) begin
                    rd_d = 1'b0;
                    dis_d = (flash_rdata_i == DIS_CODE);
                    pstrap_d = prog_s;
                    istrap_d = iface_s;
                    if (wdt_q || flash_rdata_i == DIS_CODE ||
                        req_mode(prog_s, iface_s) == BM_NONE) begin
                        rd_d = 1'b1;  // Search user code
                        addr_d = FLASH_AW'(VEC_BASE_ADDR);
                        idx_d = 3'h0;
                        sum_d = 32'h0;
                        st_d = ST_SUM;
                    end else begin
                        mode_d = req_mode(prog_s, iface_s);
                        st_d = ST_DONE;
                    end
                end
            end
            ST_SUM: begin
                if (flash_ack_i) begin
                    vec_we = 1'b1;
                    sum_d = sum_q + flash_rdata_i;
                    if (idx_q == 3'(VEC_WORDS - 1)) begin
                        rd_d = 1'b0;
                        st_d = ST_DECIDE;
                    end else begin
                        idx_d = idx_q + 3'h1;
                        addr_d = addr_q + FLASH_AW'(4);
                    end
                end
            end
            ST_DECIDE: begin
                sum_ok_d = (sum_q == 32'h0);  // Zero sum runs user
                mode_d = (sum_q == 32'h0) ? BM_USER : fall_mode(istrap_q);
                st_d = ST_DONE;
            end
            ST_DONE: st_d = ST_DONE;
            default: st_d = ST_SETTLE;
        endcase
        if (st_q != ST_DONE && st_q != ST_DECIDE &&
            dl_q == DLW'(DEADLINE_CYC - 1)) begin
            rd_d = 1'b0;
            dl_hit_d = 1'b1;  // Never decide past the deadline
            mode_d = fall_mode(iface_s);
            st_d = ST_DONE;
        end
        if (reboot) begin
            st_d = ST_SETTLE;  // Software restart reruns selection
            settle_d = '0;
            dl_d = '0;
            rd_d = 1'b0;
            mode_d = BM_NONE;
            sum_ok_d = 1'b0;
            dl_hit_d = 1'b0;
        end
    end
    // Sequencer registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_SETTLE;
            settle_q <= '0;
            dl_q <= '0;
            rd_q <= 1'b0;
            addr_q <= '0;
            mode_q <= BM_NONE;
            dis_q <= 1'b0;
            wdt_q <= 1'b0;
            pstrap_q <= 1'b1;
            istrap_q <= 1'b0;
            sum_ok_q <= 1'b0;
            dl_hit_q <= 1'b0;
        end else begin
            st_q <= st_d;
            settle_q <= settle_d;
            dl_q <= dl_d;
            idx_q <= idx_d;
            sum_q <= sum_d;
            rd_q <= rd_d;
            addr_q <= addr_d;
            mode_q <= mode_d;
            dis_q <= dis_d;
            wdt_q <= wdt_d;
            pstrap_q <= pstrap_d;
            istrap_q <= istrap_d;
            sum_ok_q <= sum_ok_d;
            dl_hit_q <= dl_hit_d;
        end
    end
    //--------------------------------------------------------------------
    // Erase and program timing
    //--------------------------------------------------------------------
    logic [TW-1:0] tmr_q, tmr_d;  // Busy countdown
    logic erase_q, erase_d;  // Erase in progress
    logic prog_q, prog_d;  // Program in progress
    logic erase_go, prog_go;  // Software start pulses
    // Timers start only in ST_DONE; a reboot does not stop a running timer
    always_comb begin
        tmr_d = tmr_q;
        erase_d = erase_q;
        prog_d = prog_q;
        if (erase_q || prog_q) begin
            tmr_d = tmr_q - TW'(1);
            if (tmr_q == TW'(1)) begin
                erase_d = 1'b0;
                prog_d = 1'b0;
            end
        end else if (st_q == ST_DONE && erase_go) begin
            tmr_d = TW'(ERASE_TIME_CYC);
            erase_d = 1'b1;
        end else if (st_q == ST_DONE && prog_go) begin
            tmr_d = TW'(PROG_TIME_CYC);
            prog_d = 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmr_q <= '0;
            erase_q <= 1'b0;
            prog_q <= 1'b0;
        end else begin
            tmr_q <= tmr_d;
            erase_q <= erase_d;
            prog_q <= prog_d;
        end
    end
    //--------------------------------------------------------------------
    // Wishbone slave, ack on third edge of a request
    //--------------------------------------------------------------------
    logic pend_q, pend_d;  // Request seen, data settling
    logic ack_q, ack_d;  // Bus acknowledge
    logic [31:0] dat_q, dat_d;  // Read data
    logic [31:0] vec_rdata;  // Stored vector word
    logic wr_ctrl;  // Control write at the edge ack is seen
    // The extra wait state lets the memory read register settle
    always_comb begin
        pend_d = wb_cyc_i && wb_stb_i && !ack_q && !pend_q;
        ack_d = wb_cyc_i && wb_stb_i && !ack_q && pend_q;
        dat_d = 32'h0;
        if (ack_d && !wb_we_i) begin
            if (wb_adr_i >= REG_VEC_BASE &&
                wb_adr_i < REG_VEC_BASE + 8'(4 * VEC_WORDS)) begin
                dat_d = vec_rdata;
            end else begin
                case (wb_adr_i)
                    REG_STATUS: dat_d = {22'h0, dl_hit_q, erase_q || prog_q,
                        sum_ok_q, dis_q, wdt_q, istrap_q, pstrap_q,
                        mode_q, st_q == ST_DONE};
                    REG_VERSION: dat_d = {24'h0, LOADER_VER};
                    REG_RETAIN_LO: dat_d = RETAIN_LO;
                    REG_RETAIN_HI: dat_d = RETAIN_HI;
                    default: dat_d = 32'h0;  // Unmapped reads zero
                endcase
            end
        end
    end
    assign wr_ctrl = ack_q && wb_cyc_i && wb_stb_i && wb_we_i &&
        wb_sel_i[0] && wb_adr_i == REG_CTRL;
    assign erase_go = wr_ctrl && wb_dat_i[CTRL_ERASE];
    assign prog_go = wr_ctrl && wb_dat_i[CTRL_PROG];
    assign reboot = wr_ctrl && wb_dat_i[CTRL_REBOOT];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q <= 1'b0;
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            pend_q <= pend_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end
    //--------------------------------------------------------------------
    // Vector word store for software inspection
    //--------------------------------------------------------------------
    bms_vec_mem #(.DW(32), .DEPTH(VEC_WORDS), .AW(3)) u_vec_mem (
        .clk_i(clk_i),
        .we_i(vec_we),
        .waddr_i(idx_q),
        .wdata_i(flash_rdata_i),
        .raddr_i(wb_adr_i[4:2]),
        .rdata_o(vec_rdata)
    );
    //--------------------------------------------------------------------
    // Outputs, all from flops
    //--------------------------------------------------------------------
    logic done_q;  // Boot decided
    logic [2:0] path_q;  // Enables: user, USB, serial
    // Path enables follow the decided mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
            path_q <= 3'h0;
        end else begin
            done_q <= (st_d == ST_DONE);
            path_q <= {(st_d == ST_DONE) && mode_d == BM_USER,
                (st_d == ST_DONE) && mode_d == BM_USB,
                (st_d == ST_DONE) && mode_d == BM_UART};
        end
    end
    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign flash_rd_o = rd_q;
    assign flash_addr_o = addr_q;
    assign flash_erase_o = erase_q;
    assign flash_prog_o = prog_q;
    assign boot_done_o = done_q;
    assign boot_mode_o = mode_q;
    assign run_user_o = path_q[2];
    assign usb_msc_en_o = path_q[1];
    assign serial_pins_en_o = path_q[0];
endmodule

// ### include/bms_pkg.sv
//------------------------------------------------------------------------
// Boot mode select constants
//------------------------------------------------------------------------
package bms_pkg;

    //--------------------------------------------------------------------
    // Clock and timing
    //--------------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int BOOT_DEADLINE_US = 3000;  // Latest decision time
    localparam int STRAP_SETTLE_US = 100;    // Least strap settle wait
    localparam int ERASE_MS = 100;           // Sector erase time
    localparam int PROG_MS = 1;              // 256-byte block program time
    localparam int PROG_BLOCK_BYTES = 256;
    // Longest time rounds down
    localparam int BOOT_DEADLINE_CYC = (CLK_HZ / 1_000_000) * BOOT_DEADLINE_US;
    // Least time rounds down too
    localparam int STRAP_SETTLE_CYC = (CLK_HZ / 1_000_000) * STRAP_SETTLE_US;
    localparam int ERASE_CYC = (CLK_HZ / 1000) * ERASE_MS;
    localparam int PROG_CYC = (CLK_HZ / 1000) * PROG_MS;

    //--------------------------------------------------------------------
    // Flash layout
    //--------------------------------------------------------------------
    localparam int VEC_WORDS = 8;                      // Checksummed words
    localparam logic [15:0] DIS_WORD_ADDR = 16'h02fc;  // Strap disable word
    localparam logic [15:0] VEC_BASE_ADDR = 16'h0000;  // Sector zero base

    //--------------------------------------------------------------------
    // Retained SRAM window, never touched by the loader
    //--------------------------------------------------------------------
    localparam logic [31:0] RETAIN_LO = 32'h1000_0000;
    localparam logic [31:0] RETAIN_HI = 32'h1000_0050;

    //--------------------------------------------------------------------
    // Loader versions, major in high nibble
    //--------------------------------------------------------------------
    localparam logic [7:0] VER_7_0 = 8'h70;
    localparam logic [7:0] VER_7_1 = 8'h71;
    localparam logic [7:0] VER_7_4 = 8'h74;

    //--------------------------------------------------------------------
    // Register map, byte addresses
    //--------------------------------------------------------------------
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_VERSION = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_RETAIN_LO = 8'h0c;
    localparam logic [7:0] REG_RETAIN_HI = 8'h10;
    localparam logic [7:0] REG_VEC_BASE = 8'h20;  // 8 words to 0x3c
    // Control bits
    localparam int CTRL_ERASE = 0;
    localparam int CTRL_PROG = 1;
    localparam int CTRL_REBOOT = 2;

    //--------------------------------------------------------------------
    // Boot outcome and sequencer states
    //--------------------------------------------------------------------
    typedef enum logic [1:0] {
        BM_NONE = 2'h0,
        BM_USER = 2'h1,
        BM_UART = 2'h2,
        BM_USB = 2'h3
    } bms_mode_type;

    typedef enum logic [2:0] {
        ST_SETTLE = 3'h0,
        ST_DISRD = 3'h1,
        ST_SUM = 3'h3,
        ST_DECIDE = 3'h2,
        ST_DONE = 3'h6
    } bms_state_type;

endpackage

// ### rtl/bms_vec_mem.sv
`timescale 1ns/10ps
module bms_vec_mem #(
    parameter int DW = 32,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // Clock
    input wire logic clk_i,
    // Write side
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [DW-1:0] wdata_i,
    // Read side
    input wire logic [AW-1:0] raddr_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_q [DEPTH];  // Storage, no reset needed
    logic [DW-1:0] rdata_q;        // Read data register

    // Write and registered read
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
        rdata_q <= mem_q[raddr_i];
    end

    assign rdata_o = rdata_q;
endmodule

// ### testbench/bms_checker_sva.sv
`timescale 1ns/10ps
module bms_checker #(
    parameter int DEADLINE_CYC = 150000,
    parameter int ERASE_TIME_CYC = 5000000,
    parameter int PROG_TIME_CYC = 50000
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Flash port
    input wire logic flash_rd_o,
    input wire logic [15:0] flash_addr_o,
    input wire logic flash_ack_i,
    input wire logic flash_erase_o,
    input wire logic flash_prog_o,
    // Outcome
    input wire logic boot_done_o,
    input wire logic [1:0] boot_mode_o,
    input wire logic run_user_o,
    input wire logic usb_msc_en_o,
    input wire logic serial_pins_en_o
);
    logic [31:0] dcnt_q, dcnt_d, ecnt_q, ecnt_d, pcnt_q, pcnt_d;
    // Next counts: time to decision, erase and program widths
    always_comb begin
        dcnt_d = boot_done_o ? dcnt_q : dcnt_q + 32'h1;
        ecnt_d = flash_erase_o ? ecnt_q + 32'h1 : 32'h0;
        pcnt_d = flash_prog_o ? pcnt_q + 32'h1 : 32'h0;
    end
    // Counters clear on reset so a second reset restarts the deadline
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dcnt_q <= 32'h0;
            ecnt_q <= 32'h0;
            pcnt_q <= 32'h0;
        end else begin
            dcnt_q <= dcnt_d;
            ecnt_q <= ecnt_d;
            pcnt_q <= pcnt_d;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    chk_ack_two_cyc: assert property ($rose(wb_cyc_i && wb_stb_i) |->
        !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o) else $error("ack late");
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_mode_map: assert property (boot_done_o |->
        run_user_o == (boot_mode_o == 2'h1) &&
        usb_msc_en_o == (boot_mode_o == 2'h3) &&
        serial_pins_en_o == (boot_mode_o == 2'h2))
        else $error("enables disagree with mode");
    chk_undone_quiet: assert property (!boot_done_o |->
        boot_mode_o == 2'h0 && !run_user_o && !usb_msc_en_o &&
        !serial_pins_en_o) else $error("outcome before decision");
    chk_deadline_bound: assert property (dcnt_q <= DEADLINE_CYC)
        else $error("decision later than deadline");
    chk_flash_hold: assert property (flash_rd_o && !flash_ack_i |=>
        flash_rd_o && $stable(flash_addr_o)) else $error("read dropped");
    chk_erase_len: assert property ($fell(flash_erase_o) |->
        ecnt_q == ERASE_TIME_CYC) else $error("erase width wrong");
    chk_prog_len: assert property ($fell(flash_prog_o) |->
        pcnt_q == PROG_TIME_CYC) else $error("program width wrong");
    // Covers for the main outcomes
    cover property ($rose(run_user_o));
    cover property ($rose(usb_msc_en_o));
    cover property ($rose(serial_pins_en_o));
    cover property ($fell(flash_prog_o));
endmodule
bind bms_top bms_checker #(.DEADLINE_CYC(DEADLINE_CYC),
    .ERASE_TIME_CYC(ERASE_TIME_CYC), .PROG_TIME_CYC(PROG_TIME_CYC))
    bms_checker_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .flash_rd_o(flash_rd_o), .flash_addr_o(flash_addr_o[15:0]),
    .flash_ack_i(flash_ack_i), .flash_erase_o(flash_erase_o),
    .flash_prog_o(flash_prog_o), .boot_done_o(boot_done_o),
    .boot_mode_o(boot_mode_o), .run_user_o(run_user_o),
    .usb_msc_en_o(usb_msc_en_o), .serial_pins_en_o(serial_pins_en_o));

// ### testbench/bms_flash_model.sv
`timescale 1ns/10ps
module bms_flash_model #(
    parameter logic [31:0] DIS_CODE = 32'h5a5a_a5a5  // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Read port
    input wire logic flash_rd_i,
    input wire logic [15:0] flash_addr_i,
    output logic [31:0] rdata_o,
    output logic ack_o,
    // Content and speed knobs
    input wire logic sum_ok_i,
    input wire logic dis_on_i,
    input wire logic slow_i
);
    logic [31:0] word_q;
    logic [1:0] wait_q;
    // Words 0..6 hold 1..7, so word 7 must be minus 28 to sum zero
    function automatic logic [31:0] word_at(input logic [15:0] a);
        if (a == 16'h02fc)
            return dis_on_i ? DIS_CODE : ~DIS_CODE;
        if (a == 16'h001c)
            return sum_ok_i ? 32'hffff_ffe4 : 32'hffff_ffe5;
        return {18'h0, a[15:2]} + 32'h1;
    endfunction
    // One or four cycles of latency per word
    always_ff @(posedge clk_i) begin
        if (rst_i || !flash_rd_i || ack_o) begin
            wait_q <= 2'h0;
            ack_o <= 1'b0;
        end else if (wait_q == (slow_i ? 2'h3 : 2'h0)) begin
            ack_o <= 1'b1;
            word_q <= word_at(flash_addr_i);
        end else begin
            wait_q <= wait_q + 2'h1;
        end
    end
    // Released data lines show the inverse, never a stale word
    assign rdata_o = ack_o ? word_q : ~word_q;
endmodule

// ### testbench/bms_top_bench.sv
`timescale 1ns/10ps
module bms_top_bench;
    import bms_pkg::*;
    localparam int DL = 20000;  // Shortened deadline
    localparam int ER = 100;    // Shortened erase time
    localparam int PR = 20;     // Shortened program time
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, flash_rdata;
    logic p_strap, i_strap, wdt, sum_ok, dis_on, slow;
    logic flash_rd, flash_ack, erase, prog, done, run_user, usb_en, ser_en;
    logic [15:0] flash_addr;
    logic [1:0] mode, mode71;
    int error_cnt = 0;
    int checks = 0;
    int cyc_cnt = 0;
    // Version 7.4 and 7.1 run in lockstep on the same pins
    bms_top #(.DEADLINE_CYC(DL), .ERASE_TIME_CYC(ER), .PROG_TIME_CYC(PR))
    bms_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .prog_request_strap_i(p_strap),
        .iface_select_strap_i(i_strap), .wdt_overflow_i(wdt),
        .flash_rd_o(flash_rd), .flash_addr_o(flash_addr),
        .flash_rdata_i(flash_rdata), .flash_ack_i(flash_ack),
        .flash_erase_o(erase), .flash_prog_o(prog), .boot_done_o(done),
        .boot_mode_o(mode), .run_user_o(run_user), .usb_msc_en_o(usb_en),
        .serial_pins_en_o(ser_en));
    bms_top #(.LOADER_VER(VER_7_1), .DEADLINE_CYC(DL),
        .ERASE_TIME_CYC(ER), .PROG_TIME_CYC(PR))
    bms_top_v71_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(),
        .wb_ack_o(), .prog_request_strap_i(p_strap),
        .iface_select_strap_i(i_strap), .wdt_overflow_i(wdt),
        .flash_rd_o(), .flash_addr_o(), .flash_rdata_i(flash_rdata),
        .flash_ack_i(flash_ack), .flash_erase_o(), .flash_prog_o(),
        .boot_done_o(), .boot_mode_o(mode71), .run_user_o(),
        .usb_msc_en_o(), .serial_pins_en_o());
    bms_flash_model bms_flash_model_i (.clk_i(clk_i), .rst_i(rst_i),
        .flash_rd_i(flash_rd), .flash_addr_i(flash_addr),
        .rdata_o(flash_rdata), .ack_o(flash_ack), .sum_ok_i(sum_ok),
        .dis_on_i(dis_on), .slow_i(slow));
    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: %h not %h", $time, what, seen, exp);
        end
    endtask
    // Counts and verdict
    task results;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One classic cycle; waits for ack, only the timeout cuts it
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Reset with straps {req,iface,wdt,sum_ok,dis,slow}, then judge
    task automatic boot(input logic [5:0] cfg, input logic [1:0] m74,
                        input logic [1:0] m71);
        logic [31:0] r;
        @(posedge clk_i);
        rst_i <= 1'b1;
        {p_strap, i_strap, wdt, sum_ok, dis_on, slow} <= cfg;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        do @(posedge clk_i); while (done !== 1'b1);
        check({30'h0, mode}, {30'h0, m74}, "mode");
        check({30'h0, mode71}, {30'h0, m71}, "mode v7.1");
        check({29'h0, run_user, usb_en, ser_en}, (m74 == 2'h1) ? 32'h4 :
            (m74 == 2'h3) ? 32'h2 : 32'h1, "enables");
        wb(1'b0, REG_STATUS, 32'h0, r);
        check({29'h0, r[2:0]}, {29'h0, m74, 1'b1}, "status");
        $display("boot test %b done", cfg);
    endtask
    // Width of an erase or program pulse in cycles
    task automatic pulse(input logic pg, input int exp);
        logic [31:0] r;
        int n;
        n = 0;
        wb(1'b1, REG_CTRL, pg ? 32'h2 : 32'h1, r);
        do @(posedge clk_i); while ((pg ? prog : erase) !== 1'b1);
        while ((pg ? prog : erase) === 1'b1) begin
            @(posedge clk_i);
            n++;
        end
        check(32'(n), 32'(exp), "pulse width");
    endtask
    // Hang guard
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 60000) begin
            error_cnt++;
            $display("[FAIL] %0t run timed out", $time);
            results();
        end
    end
    // Main sequence
    initial begin
        logic [31:0] r;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} = '0;
        wb_dat_i = 32'h0;
        {p_strap, i_strap, wdt, sum_ok, dis_on, slow} = 6'b110000;
        boot(6'b111100, 2'h1, 2'h1);
        boot(6'b110001, 2'h3, 2'h2);
        boot(6'b000000, 2'h2, 2'h2);
        boot(6'b010001, 2'h3, 2'h2);
        boot(6'b011100, 2'h1, 2'h1);
        boot(6'b010110, 2'h1, 2'h1);
        boot(6'b100001, 2'h2, 2'h2);
        wb(1'b1, REG_VERSION, 32'hffff_ffff, r);
        wb(1'b0, REG_VERSION, 32'h0, r);
        check(r, {24'h0, VER_7_4}, "version");
        wb(1'b0, REG_RETAIN_LO, 32'h0, r);
        check(r, RETAIN_LO, "retain low");
        wb(1'b0, REG_RETAIN_HI, 32'h0, r);
        check(r, RETAIN_HI, "retain high");
        wb(1'b0, 8'h40, 32'h0, r);
        check(r, 32'h0, "unmapped");
        pulse(1'b0, ER);
        pulse(1'b1, PR);
        $display("register and timing test done");
        results();
    end
endmodule
